// File: pmc_consts.svh
// Constants for the power mode controller
// Operation
// - Reset enters RUN with full master clock
// - Slow enable plus two-bit prescale field
// - Slow divides master clock by 2..16
// - Wait while slow gives slow-wait
// - Wait stops CPU, peripherals stay clocked
// - Wait entry forces priority bits to 10
// - Wait ends on interrupt or reset vector
// - Halt picks halt or active-halt by enable
// - Active-halt left only by reset or listed wake sources
// - Interrupt exit from active-halt has no delay
// - Reset exit from active-halt is delayed
// - Active-halt entry forces 10, pending wakes
// - Active-halt keeps only oscillator and time base
// - Externally clocked peripherals keep running
// - Active-halt suppresses the watchdog reset
// - Time base interrupt always wakes active-halt
// - Service pushes CC, loads level, pop restores
// - Halt stops oscillator, wake waits delay
// - Flash parts leave active-halt only by reset or time base
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH
`define PMC_CTRL_OFS 4'h0
`define PMC_STAT_OFS 4'h4
`define PMC_SLOW_BIT 0
`define PMC_PSC_LSB 1
`define PMC_OIE_BIT 3
`define PMC_LONG_BIT 4
`define PMC_STAB_SHORT 13'd256
`define PMC_STAB_LONG 13'd4096
`define PMC_PRIO_ALL 2'b10
`define PMC_PRIO_RST 2'b11
`define PMC_RESP_OK 2'b00
`define PMC_RESP_ERR 2'b10
`endif

// File: pmc_pkg.sv
// Types of the power mode controller
package pmc_pkg;
  typedef enum logic [2:0] {
    MODE_RUN,
    MODE_WAIT,
    MODE_AHALT,
    MODE_HALT,
    MODE_STAB
  } pmc_mode_t;

  typedef struct packed {
    logic cpu;
    logic periph;
    logic time_base;
    logic osc;
  } pmc_gate_t;

  typedef struct packed {
    logic       slow_clock_enable;
    logic [1:0] cpu_prescale_select;
    logic       oscillator_irq_enable;
    logic       long_delay;
  } pmc_ctrl_t;

  typedef struct packed {
    pmc_mode_t  mode;
    pmc_ctrl_t  ctrl;
    logic       slow_act;
    logic [1:0] psc_act;
    logic [3:0] div_cnt;
    logic [12:0] cnt;
    logic       stab_rst;
    logic       stab_guard;
    logic [1:0] prio;
    logic [1:0] prio_saved;
    logic [2:0] sync1;
    logic [2:0] sync2;
    pmc_gate_t  gate;
    logic       irq_resume;
    logic       rst_vector;
    logic       cc_push;
    logic       wdg_block;
    logic       awv;
    logic [3:0] awaddr;
    logic       wv;
    logic [4:0] wdata;
    logic       wstrb0;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic       awready;
    logic       wready;
    logic       arready;
  } pmc_state_t;
endpackage

// File: pmc_power_mode_controller.sv
// Power mode controller with AXI4-Lite control registers
//
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`include "pmc_consts.svh"
module pmc_power_mode_controller
  import pmc_pkg::*;
#(
  parameter bit FLASH_VARIANT = 1'b1
) (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        wfi_instr_i,
  input  wire logic        halt_instr_i,
  input  wire logic        cc_pop_i,
  input  wire logic [1:0]  irq_level_i,
  input  wire logic        time_base_irq_i,
  input  wire logic        wake_irq_i,
  input  wire logic        other_irq_i,
  input  wire logic        reset_req_i,
  output logic             cpu_clk_en_o,
  output logic             periph_clk_en_o,
  output logic             time_base_clk_en_o,
  output logic             osc_on_o,
  output logic [1:0]       prio_o,
  output logic             irq_resume_o,
  output logic             rst_vector_o,
  output logic             cc_push_o,
  output logic             wdg_block_o,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // Whole block state and its next value
  pmc_state_t q;
  pmc_state_t d;

  // Helper nets derived from the state
  logic        wake_s;
  logic        other_s;
  logic        rstreq_s;
  logic        irq_any;
  logic        ahalt_wake;
  logic        tick;
  logic [3:0]  div_lim;
  logic [12:0] stab_len;
  logic        do_write;
  logic [31:0] rd_word;

  // Synchronised pin inputs, second stage only
  assign wake_s   = q.sync2[0];
  assign other_s  = q.sync2[1];
  assign rstreq_s = q.sync2[2];
  // Time base shares the clock and needs no synchroniser
  assign irq_any  = time_base_irq_i | wake_s | other_s;

  // Wake sources accepted in active-halt
  assign ahalt_wake = time_base_irq_i | (wake_s & ~FLASH_VARIANT);

  // Divider limit from the settings in force
  assign div_lim = q.slow_act ? 4'((5'd2 << q.psc_act) - 5'd1) : 4'h0;
  assign tick    = (q.div_cnt == div_lim);
  // Settle delay length chosen by software
  assign stab_len = q.ctrl.long_delay ? `PMC_STAB_LONG : `PMC_STAB_SHORT;

  // Register read mux
  always_comb begin
    rd_word = 32'h0;
    case (s_axi_araddr[3:0])
      `PMC_CTRL_OFS: rd_word = {27'h0, q.ctrl};
      `PMC_STAT_OFS: rd_word = {22'h0,
                                q.stab_guard, // Guard stall
                                q.stab_rst,   // Stall caused by reset
                                q.psc_act,    // Prescale in force
                                q.slow_act,   // Slow divider in force
                                q.prio,       // Priority bits
                                3'(q.mode)};  // Current mode
      default: rd_word = 32'h0;
    endcase
  end

  // Write executes once both halves are held and the last answer is gone
  assign do_write = q.awv & q.wv & ~q.bvalid;

  // Next state of the whole block
  always_comb begin
    d = q;
    // Two-stage synchronisers for the pins from other domains
    d.sync1 = {reset_req_i, other_irq_i, wake_irq_i};
    d.sync2 = q.sync1;
    // Pulses last one cycle unless set again below
    d.irq_resume = 1'b0;
    d.rst_vector = 1'b0;
    d.cc_push    = 1'b0;

    // Write address and data taken in either order
    if (s_axi_awvalid && !q.awv) begin
      d.awv    = 1'b1;
      d.awaddr = s_axi_awaddr[3:0];
    end
    if (s_axi_wvalid && !q.wv) begin
      d.wv     = 1'b1;
      d.wdata  = s_axi_wdata[4:0];
      d.wstrb0 = s_axi_wstrb[0];
    end
    if (do_write) begin
      d.awv    = 1'b0;
      d.wv     = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = `PMC_RESP_OK;
      case (q.awaddr)
        `PMC_CTRL_OFS: begin
          if (q.wstrb0) begin
            d.ctrl.slow_clock_enable     = q.wdata[`PMC_SLOW_BIT];
            d.ctrl.cpu_prescale_select   = q.wdata[`PMC_PSC_LSB +: 2];
            d.ctrl.oscillator_irq_enable = q.wdata[`PMC_OIE_BIT];
            d.ctrl.long_delay            = q.wdata[`PMC_LONG_BIT];
          end
        end
        `PMC_STAT_OFS: d.bresp = `PMC_RESP_OK; // Read-only, write ignored
        default: d.bresp = `PMC_RESP_ERR;
      endcase
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end

    // Read channel
    if (s_axi_arvalid && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.rdata  = rd_word;
      d.rresp  = ((s_axi_araddr[3:0] == `PMC_CTRL_OFS) ||
                  (s_axi_araddr[3:0] == `PMC_STAT_OFS)) ? `PMC_RESP_OK : `PMC_RESP_ERR;
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end

    // Clock divider, settings latched only at a boundary
    if (tick) begin
      d.div_cnt  = 4'h0;
      d.slow_act = q.ctrl.slow_clock_enable;
      d.psc_act  = q.ctrl.cpu_prescale_select;
    end else begin
      d.div_cnt = 4'(q.div_cnt + 4'h1);
    end

    // Priority restore on pop
    if (cc_pop_i) begin
      d.prio = q.prio_saved;
    end

    // Mode sequencer
    case (q.mode)
      MODE_RUN: begin
        // Guard window left over from an active-halt wake
        if (q.cnt != 13'h0) begin
          d.cnt = 13'(q.cnt - 13'h1);
        end
        // Reset request is served at once, the oscillator never stopped
        if (rstreq_s) begin
          d.rst_vector = 1'b1;
          d.prio       = `PMC_PRIO_RST;
          d.cnt        = 13'h0;
        end else if (q.cnt != 13'h0 && !q.ctrl.oscillator_irq_enable) begin
          d.mode       = MODE_STAB;
          d.stab_guard = 1'b1;
          d.stab_rst   = 1'b0;
        end else if (halt_instr_i) begin
          d.prio = `PMC_PRIO_ALL;
          d.cnt  = 13'h0;
          if (q.ctrl.oscillator_irq_enable) begin
            d.mode = MODE_AHALT;
          end else begin
            d.mode = MODE_HALT;
          end
        end else if (wfi_instr_i) begin
          d.mode = MODE_WAIT;
          d.prio = `PMC_PRIO_ALL;
        end
      end
      MODE_WAIT: begin
        // Any interrupt ends wait; a reset request takes precedence
        if (rstreq_s) begin
          d.mode       = MODE_RUN;
          d.rst_vector = 1'b1;
          d.prio       = `PMC_PRIO_RST;
        end else if (irq_any) begin
          d.mode       = MODE_RUN;
          d.irq_resume = 1'b1;
          d.cc_push    = 1'b1;
          d.prio_saved = q.prio;
          d.prio       = irq_level_i;
        end
      end
      MODE_AHALT: begin
        // Only listed sources wake; a reset restarts through the delay
        if (rstreq_s) begin
          d.mode       = MODE_STAB;
          d.cnt        = stab_len;
          d.stab_rst   = 1'b1;
          d.stab_guard = 1'b0;
        end else if (ahalt_wake) begin
          d.mode       = MODE_RUN;
          d.irq_resume = 1'b1;
          d.cc_push    = 1'b1;
          d.prio_saved = q.prio;
          d.prio       = irq_level_i;
          d.cnt        = stab_len; // Guard window for the enable bit
        end
      end
      MODE_HALT: begin
        // Oscillator is off, so every exit waits for it to settle
        if (rstreq_s || wake_s) begin
          d.mode       = MODE_STAB;
          d.cnt        = stab_len;
          d.stab_rst   = rstreq_s;
          d.stab_guard = 1'b0;
        end
      end
      MODE_STAB: begin
        // Count the settle delay down, then hand control back
        if (q.cnt != 13'h0) begin
          d.cnt = 13'(q.cnt - 13'h1);
        end else begin
          d.mode       = MODE_RUN;
          d.stab_guard = 1'b0;
          d.stab_rst   = 1'b0;
          // A guard stall ends silently; its interrupt was served already
          if (q.stab_rst) begin
            d.rst_vector = 1'b1;
            d.prio       = `PMC_PRIO_RST;
          end else if (!q.stab_guard) begin
            d.irq_resume = 1'b1;
            d.cc_push    = 1'b1;
            d.prio_saved = q.prio;
            d.prio       = irq_level_i;
          end
        end
      end
      // Unknown codes fall back to run
      default: d.mode = MODE_RUN;
    endcase

    // Clock gates follow the mode being entered
    d.gate.cpu       = (d.mode == MODE_RUN) & tick;
    d.gate.periph    = ((d.mode == MODE_RUN) | (d.mode == MODE_WAIT)) & tick;
    d.gate.time_base = (d.mode == MODE_RUN) | (d.mode == MODE_WAIT) |
                       (d.mode == MODE_AHALT);
    d.gate.osc       = (d.mode != MODE_HALT);
    // Watchdog is held off only while active-halt lasts
    d.wdg_block      = (d.mode == MODE_AHALT);

    // Ready flags mirror the holding flops so the outputs leave a register
    d.awready = ~d.awv;
    d.wready  = ~d.wv;
    d.arready = ~d.rvalid;
  end

  // State register
  // Priority bits come up masked and all channels ready, as after any reset
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      q         <= '0;
      q.prio    <= `PMC_PRIO_RST;
      q.awready <= 1'b1;
      q.wready  <= 1'b1;
      q.arready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign cpu_clk_en_o       = q.gate.cpu;
  assign periph_clk_en_o    = q.gate.periph;
  assign time_base_clk_en_o = q.gate.time_base;
  assign osc_on_o           = q.gate.osc;
  assign prio_o             = q.prio;
  assign irq_resume_o       = q.irq_resume;
  assign rst_vector_o       = q.rst_vector;
  assign cc_push_o          = q.cc_push;
  assign wdg_block_o        = q.wdg_block;
  // Bus handshake outputs, each from its own flop
  assign s_axi_awready      = q.awready;
  assign s_axi_wready       = q.wready;
  assign s_axi_bvalid       = q.bvalid;
  assign s_axi_bresp        = q.bresp;
  assign s_axi_arready      = q.arready;
  assign s_axi_rvalid       = q.rvalid;
  assign s_axi_rdata        = q.rdata;
  assign s_axi_rresp        = q.rresp;

endmodule

// File: pmc_properties.sv
// Output relations of the power mode controller
`timescale 1ns/10ps
module pmc_properties (
  input wire logic       clk_i,
  input wire logic       reset_i,
  input wire logic       time_base_irq_i,
  input wire logic       cpu_clk_en_o,
  input wire logic       periph_clk_en_o,
  input wire logic       time_base_clk_en_o,
  input wire logic       osc_on_o,
  input wire logic [1:0] prio_o,
  input wire logic       irq_resume_o,
  input wire logic       rst_vector_o,
  input wire logic       cc_push_o,
  input wire logic       wdg_block_o
);
  // One clock domain, disabled in reset
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  a_ahalt_prio: assert property ($rose(wdg_block_o) |-> prio_o == 2'b10)
    else $error("priority not opened on halt entry");
  a_ahalt_gates: assert property (wdg_block_o |-> time_base_clk_en_o && osc_on_o
    && !cpu_clk_en_o && !periph_clk_en_o) else $error("clocks wrong in active halt");
  a_halt_gates: assert property (!osc_on_o |-> !cpu_clk_en_o && !periph_clk_en_o
    && !time_base_clk_en_o) else $error("clock runs with oscillator off");
  a_push_pair: assert property (irq_resume_o |-> cc_push_o && !rst_vector_o)
    else $error("resume without push");
  a_resume_once: assert property (irq_resume_o |=> !irq_resume_o)
    else $error("resume pulse too long");
  a_rstvec_prio: assert property (rst_vector_o |-> prio_o == 2'b11 ##1 !rst_vector_o)
    else $error("reset vector pulse wrong");
  a_cpu_periph: assert property (cpu_clk_en_o |-> periph_clk_en_o)
    else $error("cpu ticks without peripherals");
  a_wait_prio: assert property (periph_clk_en_o && !cpu_clk_en_o |-> prio_o == 2'b10)
    else $error("wait priority not forced");
  a_tb_wake: assert property (wdg_block_o && time_base_irq_i |=> irq_resume_o)
    else $error("time base did not wake");
endmodule
bind pmc_power_mode_controller pmc_properties u_props (.clk_i(clk_i), .reset_i(reset_i),
  .time_base_irq_i(time_base_irq_i), .cpu_clk_en_o(cpu_clk_en_o),
  .periph_clk_en_o(periph_clk_en_o), .time_base_clk_en_o(time_base_clk_en_o),
  .osc_on_o(osc_on_o), .prio_o(prio_o), .irq_resume_o(irq_resume_o),
  .rst_vector_o(rst_vector_o), .cc_push_o(cc_push_o), .wdg_block_o(wdg_block_o));

// File: pmc_core_model.sv
// Processor core model issuing wait and halt and popping CC
`timescale 1ns/10ps
module pmc_core_model (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic go_wfi_i,
  input  wire logic go_halt_i,
  input  wire logic irq_resume_i,
  output logic      wfi_instr_o,
  output logic      halt_instr_o,
  output logic      cc_pop_o
);
  logic [2:0] pop_q;
  // One-cycle instruction strobes; the routine returns four cycles in
  always_ff @(posedge clk_i) begin
    wfi_instr_o <= go_wfi_i && !reset_i;
    halt_instr_o <= go_halt_i && !reset_i;
    cc_pop_o <= pop_q == 3'h1 && !reset_i;
    if (reset_i || pop_q == 3'h0 && !irq_resume_i)
      pop_q <= 3'h0;
    else
      pop_q <= irq_resume_i ? 3'h4 : pop_q - 3'h1;
  end
endmodule

// File: testbench.sv
// Self-checking bench for the power mode controller
`timescale 1ns/10ps
module testbench;
  logic        clk_i, reset_i, gw, gh, tbq, wkq, otq, rq, wait_for_irq_instr, hlt, pop;
  logic        cpu, per, tbe, osc, res, rvec, push, wdg;
  logic        awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  logic [1:0]  lvl, prio, bresp, rresp;
  logic [31:0] awaddr, wdata, araddr, rdata, rd;
  int          n_errors, n_checks, n, c;
  int          m_prio, m_stack[$]; // Model of the priority bits and the stack
  pmc_power_mode_controller dut (.clk_i(clk_i), .reset_i(reset_i), .wfi_instr_i(wait_for_irq_instr),
    .halt_instr_i(hlt), .cc_pop_i(pop), .irq_level_i(lvl), .time_base_irq_i(tbq),
    .wake_irq_i(wkq), .other_irq_i(otq), .reset_req_i(rq), .cpu_clk_en_o(cpu),
    .periph_clk_en_o(per), .time_base_clk_en_o(tbe), .osc_on_o(osc), .prio_o(prio),
    .irq_resume_o(res), .rst_vector_o(rvec), .cc_push_o(push), .wdg_block_o(wdg),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(araddr),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr));
  pmc_core_model core (.clk_i(clk_i), .reset_i(reset_i), .go_wfi_i(gw), .go_halt_i(gh),
    .irq_resume_i(res), .wfi_instr_o(wait_for_irq_instr), .halt_instr_o(hlt), .cc_pop_o(pop));
  // Free-running master clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic axi_wr(input logic [31:0] a, d);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (awv && !awr || wv && !wr);
    while (!bv) @(posedge clk_i);
    br <= 1'b0;
  endtask
  task automatic axi_rd(input logic [31:0] a);
    araddr <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do @(posedge clk_i); while (!arr);
    arv <= 1'b0;
    do @(posedge clk_i); while (!rv);
    rd = rdata;
    rr <= 1'b0;
  endtask
  // Counts cpu or peripheral ticks over 64 cycles
  task automatic ticks(input bit p, output int k);
    k = 0;
    repeat (64) begin
      @(posedge clk_i);
      k += p ? per : cpu;
    end
  endtask
  task automatic pulse(input bit h);
    if (h) gh <= 1'b1;
    else gw <= 1'b1;
    @(posedge clk_i);
    gh <= 1'b0;
    gw <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  // Cycles until resume or reset-vector pulse
  task automatic wait_hi(input bit v, output int k);
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (!(v ? rvec : res) && k < 9000);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    n_errors++;
    print_verdict();
  end
  initial begin
    {reset_i, gw, gh, tbq, wkq, otq, rq, awv, wv, br, arv, rr} = 12'h800;
    {awaddr, wdata, araddr, lvl} = '0;
    void'($urandom(32'hf8ebf1a3));
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    m_prio = 3;
    @(posedge clk_i);
    check("prio_rst", prio, m_prio);
    axi_rd(32'h0);
    check("ctrl_rst", rd, 32'h0);
    ticks(0, c);
    check("run_ticks", c, 64);
    axi_rd(32'h8);
    check("unmapped", rresp, 2'b10);
    check("unmapped_rd", rd, 32'h0);
    axi_wr(32'h8, 32'h1f);
    check("unmapped_wr", bresp, 2'b10);
    axi_rd(32'h0);
    check("unmapped_nop", rd, 32'h0);
    for (int p = 0; p < 4; p++) begin
      axi_wr(32'h0, 32'h1 | p << 1);
      check("wr_okay", bresp, 2'b00);
      repeat (40) @(posedge clk_i);
      ticks(0, c);
      check("slow_ticks", c, 64 >> (p + 1));
    end
    pulse(0);
    axi_rd(32'h4);
    check("slow_wait", {rd[5], rd[2:0]}, 4'h9);
    ticks(1, c);
    check("wait_per", c, 4);
    m_prio = 2;
    check("wait_prio", prio, m_prio);
    lvl <= 2'($urandom_range(3, 0));
    otq <= 1'b1;
    wait_hi(0, n);
    check("wait_wake", n <= 8, 1);
    m_stack.push_back(m_prio);
    m_prio = lvl;
    check("irq_level", prio, m_prio);
    otq <= 1'b0;
    repeat (8) @(posedge clk_i);
    m_prio = m_stack.pop_back();
    check("pop_prio", prio, m_prio);
    axi_wr(32'h0, 32'h10);
    pulse(1);
    check("halt_osc", osc, 1'b0);
    wkq <= 1'b1;
    wait_hi(0, n);
    check("halt_dly", n >= 4097 && n <= 4110, 1);
    wkq <= 1'b0;
    axi_wr(32'h0, 32'h8);
    pulse(1);
    check("ahalt_prio", {wdg, prio}, 3'h6);
    {wkq, otq} <= 2'b11;
    repeat (20) @(posedge clk_i);
    check("ahalt_stay", wdg, 1'b1);
    {wkq, otq} <= 2'b00;
    repeat (4) @(posedge clk_i);
    tbq <= 1'b1;
    wait_hi(0, n);
    check("tb_wake", n <= 2, 1);
    tbq <= 1'b0;
    axi_wr(32'h0, 32'h0);
    axi_rd(32'h4);
    check("guard_stab", rd[2:0], 3'h4);
    repeat (300) @(posedge clk_i);
    axi_wr(32'h0, 32'h8);
    pulse(1);
    rq <= 1'b1;
    repeat (4) @(posedge clk_i);
    rq <= 1'b0;
    wait_hi(1, n);
    n += 4;
    check("rst_dly", n >= 257 && n <= 270, 1);
    repeat (8) @(posedge clk_i);
    print_verdict();
  end
endmodule
